// >>> design/dtcp_pkg.sv
// package: register map, field positions, reset values and carrier types of the trace count block
package dtcp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_TRACE_DATA = 8'h04;
  localparam logic [7:0] OFS_WORD_COUNT = 8'h08;
  localparam logic [7:0] OFS_PAGE_EXT   = 8'h0C;
  localparam logic [7:0] OFS_COMP_C     = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // control register fields
  localparam int CTL_ARM      = 0;
  localparam int CTL_BEGIN    = 1;
  localparam int CTL_BRK_EN   = 2;
  localparam int CTL_CC_EN    = 3;
  localparam int CTL_CAPMOD_L = 4;
  localparam int CTL_CAPMOD_H = 5;
  localparam int CTL_BKP_MODE = 6;

  // word count register fields
  localparam int CNT_FULL_BIT = 7;

  // page extension register fields
  localparam int PGX_SEL_H = 7;
  localparam int PGX_SEL_L = 6;

  // interrupt status bits
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_FULL  = 1;
  localparam int IRQ_MATCH = 2;
  localparam int IRQ_W     = 3;

  ////////////////////////////////////////////////////////////////////////////
  // sizes and reset values
  localparam int TRACE_DEPTH = 64;
  localparam int TRACE_AW    = 6;
  localparam int TRACE_DW    = 16;

  localparam logic [7:0]        CONTROL_RST  = 8'h00;
  localparam logic [7:0]        PAGE_EXT_RST = 8'h00;
  localparam logic [15:0]       COMP_C_RST   = 16'h0000;
  localparam logic [IRQ_W-1:0]  IRQ_RST      = 3'h0;
  localparam logic [TRACE_AW-1:0] PTR_RST    = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  ext_addr;
    logic        rw;
  } dtcp_core_t;

  typedef struct packed {
    logic                valid;
    logic                trigger;
    logic [TRACE_DW-1:0] data;
  } dtcp_trace_t;

endpackage : dtcp_pkg

// >>> design/dtcp_trace_ram.sv
// trace storage: flip-flop array, one write port, one asynchronous read port
module dtcp_trace_ram #(
  parameter int DEPTH = 64,
  parameter int AW    = 6,
  parameter int DW    = 16
) (
  // clock
  input  wire logic          clk,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [DW-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0] rd_idx,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem [DEPTH];

  // no reset: contents are undefined until written
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  assign rd_data = mem[rd_idx];

endmodule : dtcp_trace_ram

// >>> design/dtcp_comp_c.sv
// comparator c address match with page extension
module dtcp_comp_c (
  // configuration
  input  wire logic        [7:0]  page_ext,
  input  wire logic        [15:0] comp_addr,
  // core bus
  input  dtcp_pkg::dtcp_core_t    core,
  // result
  output logic                    hit
);
  import dtcp_pkg::*;

  logic       page_mode;
  logic [5:0] extended_compare_field;

  // high select bit has no paging behind it, so only the low bit matters
  assign page_mode              = page_ext[PGX_SEL_L];
  assign extended_compare_field = page_ext[5:0];

  always_comb begin
    if (!page_mode) begin
      hit = core.valid && (core.addr == comp_addr);
    end else begin
      // program page drives bits 21:14, so 15:14 come from the page lines
      hit = core.valid
         && (extended_compare_field == core.ext_addr[7:2])
         && (comp_addr[15:14] == core.ext_addr[1:0])
         && (comp_addr[13:0] == core.addr[13:0]);
    end
  end

endmodule : dtcp_comp_c

// >>> design/dtcp_top.sv
// trace buffer read port, trace word counter and comparator c page compare behind an apb slave
//
// The APB register port and the address map are this design's own decisions.

// Functional notes
// - trace data reads only on aligned word reads; other reads give zero, pointer holds
// - while armed, word reads of trace data give zero, pointer held at zero
// - trace data shows storage contents directly; no reset value
// - full flag in count bit 7 once 64 words stored; all entries valid
// - writing one to arm clears the full flag
// - six-bit count in bits 5:0 gives number of valid words
// - counter wrap sets full; end-trigger mode keeps counting
// - writing one to arm clears counter and full flag together
// - full with count zero in begin mode clears arm, breaks if enabled
// - full with nonzero count: 64 valid, oldest overwritten circularly
// - page select bits 7:6; bit 7 ignored
// - select 00 plain 64k compare; 01 compares extended field to bits 21:16
// - program page on extended lines supplies compare address bits 21:14
// - comparator c usable in breakpoint mode using page select
// - begin option one starts storing at trigger; zero ends at trigger
// - completion break enable requests cpu breakpoint at session end
module dtcp_top (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // core side
  input  dtcp_pkg::dtcp_core_t       core,
  input  dtcp_pkg::dtcp_trace_t      trace_in,
  // events
  output logic                       break_request,
  output logic                       comp_c_match,
  output logic                       irq
);
  import dtcp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]              control;
  logic [7:0]              page_ext;
  logic [15:0]             comp_addr;
  logic [IRQ_W-1:0]        irq_status;
  logic [IRQ_W-1:0]        irq_mask;
  logic [TRACE_AW-1:0]     valid_word_counter;
  logic                    buffer_full_flag;
  logic [TRACE_AW-1:0]     rd_ptr;
  logic                    triggered;
  logic                    armed_d;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic                    acc_first;
  logic                    acc_done;
  logic                    wr_done;
  logic                    rd_done;
  logic                    aligned;
  logic                    mapped;
  logic                    arm_write;
  logic                    wr_control;
  logic                    wr_page_ext;
  logic                    wr_comp_c;
  logic                    wr_irq_mask;

  assign acc_first = psel && penable && !pready;
  assign acc_done  = psel && penable && pready;
  assign wr_done   = acc_done && pwrite;
  assign rd_done   = acc_done && !pwrite;
  assign aligned   = (paddr[1:0] == 2'h0);
  assign arm_write = wr_control && pwdata[CTL_ARM];

  always_comb begin
    if (paddr[7:2] == OFS_CONTROL[7:2]) begin
      mapped = 1'b1;
    end else if (paddr[7:2] == OFS_TRACE_DATA[7:2]) begin
      mapped = 1'b1;
    end else if (paddr[7:2] == OFS_WORD_COUNT[7:2]) begin
      mapped = 1'b1;
    end else if (paddr[7:2] == OFS_PAGE_EXT[7:2]) begin
      mapped = 1'b1;
    end else if (paddr[7:2] == OFS_COMP_C[7:2]) begin
      mapped = 1'b1;
    end else if (paddr[7:2] == OFS_IRQ_STATUS[7:2]) begin
      mapped = 1'b1;
    end else if (paddr[7:2] == OFS_IRQ_MASK[7:2]) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // one strobe per writable register; misaligned and unmapped writes are dropped
  always_comb begin
    wr_control  = 1'b0;
    wr_page_ext = 1'b0;
    wr_comp_c   = 1'b0;
    wr_irq_mask = 1'b0;
    if (!(wr_done && aligned)) begin
      wr_control = 1'b0;
    end else if (paddr == OFS_CONTROL) begin
      wr_control = 1'b1;
    end else if (paddr == OFS_PAGE_EXT) begin
      wr_page_ext = 1'b1;
    end else if (paddr == OFS_COMP_C) begin
      wr_comp_c = 1'b1;
    end else if (paddr == OFS_IRQ_MASK) begin
      wr_irq_mask = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trace capture
  logic                    armed;
  logic                    begin_mode;
  logic                    store;
  logic                    wrap;
  logic                    begin_done;
  logic                    end_done;
  logic                    session_done;
  logic [TRACE_DW-1:0]     ram_rd;
  logic                    cc_hit;

  assign armed      = control[CTL_ARM];
  assign begin_mode = control[CTL_BEGIN];
  // begin mode waits for the trigger; end mode records until it
  assign store      = armed && trace_in.valid && (begin_mode ? (triggered || trace_in.trigger) : 1'b1);
  assign wrap       = store && (valid_word_counter == 6'h3F);
  assign begin_done = wrap && begin_mode;
  assign end_done   = armed && !begin_mode && trace_in.trigger;
  assign session_done = begin_done || end_done;

  dtcp_trace_ram #(
    .DEPTH (TRACE_DEPTH),
    .AW    (TRACE_AW),
    .DW    (TRACE_DW)
  ) u_ram (
    .clk     (clk),
    .wr_en   (store),
    .wr_idx  (valid_word_counter),
    .wr_data (trace_in.data),
    .rd_idx  (rd_ptr),
    .rd_data (ram_rd)
  );

  dtcp_comp_c u_comp_c (
    .page_ext  (page_ext),
    .comp_addr (comp_addr),
    .core      (core),
    .hit       (cc_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait state so read data leaves a flip-flop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
    end else begin
      pready <= acc_first;
    end
  end

  // unmapped addresses answer with an error in the same cycle as ready
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= acc_first && !mapped;
    end
  end

  // read data mux; writes and refused reads answer with zero
  logic [31:0]             next_prdata;

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (pwrite || !aligned) begin
      next_prdata = 32'h0000_0000;
    end else if (paddr == OFS_CONTROL) begin
      next_prdata[7:0] = control;
    end else if (paddr == OFS_TRACE_DATA) begin
      // armed reads give zero so capture is never disturbed
      next_prdata[15:0] = armed ? 16'h0000 : ram_rd;
    end else if (paddr == OFS_WORD_COUNT) begin
      next_prdata[CNT_FULL_BIT] = buffer_full_flag;
      next_prdata[TRACE_AW-1:0] = valid_word_counter;
    end else if (paddr == OFS_PAGE_EXT) begin
      next_prdata[7:0] = page_ext;
    end else if (paddr == OFS_COMP_C) begin
      next_prdata[15:0] = comp_addr;
    end else if (paddr == OFS_IRQ_STATUS) begin
      next_prdata[IRQ_W-1:0] = irq_status;
    end else if (paddr == OFS_IRQ_MASK) begin
      next_prdata[IRQ_W-1:0] = irq_mask;
    end else begin
      next_prdata = 32'h0000_0000;
    end
  end

  // latched on every first access cycle, so an error answer never shows stale data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (acc_first) begin
      prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register; hardware clears arm at session end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      control <= CONTROL_RST;
    end else if (wr_control) begin
      control <= pwdata[7:0];
    end else if (session_done) begin
      control[CTL_ARM] <= 1'b0;
    end
  end

  // page extension and comparator c address
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      page_ext  <= PAGE_EXT_RST;
      comp_addr <= COMP_C_RST;
    end else begin
      if (wr_page_ext) begin
        page_ext <= pwdata[7:0];
      end
      if (wr_comp_c) begin
        comp_addr <= pwdata[15:0];
      end
    end
  end

  // trigger seen since arming, for begin mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      triggered <= 1'b0;
    end else if (arm_write || !armed) begin
      triggered <= 1'b0;
    end else if (trace_in.trigger) begin
      triggered <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word counter and full flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      valid_word_counter <= PTR_RST;
      buffer_full_flag   <= 1'b0;
    end else if (arm_write) begin
      valid_word_counter <= PTR_RST;
      buffer_full_flag   <= 1'b0;
    end else if (store) begin
      // end mode keeps counting past the wrap, overwriting the oldest
      valid_word_counter <= valid_word_counter + 6'h01;
      if (wrap) begin
        buffer_full_flag <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read pointer: oldest entry once capture stops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      armed_d <= 1'b0;
    end else begin
      armed_d <= armed;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_ptr <= PTR_RST;
    end else if (armed) begin
      rd_ptr <= PTR_RST;
    end else if (armed_d) begin
      rd_ptr <= buffer_full_flag ? valid_word_counter : PTR_RST;
    end else if (rd_done && aligned && paddr == OFS_TRACE_DATA) begin
      rd_ptr <= rd_ptr + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // breakpoint request and comparator c match pulses
  logic cc_armed;

  // comparator c also serves as a breakpoint in breakpoint mode
  assign cc_armed = control[CTL_CC_EN] && (armed || control[CTL_BKP_MODE]);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      break_request <= 1'b0;
      comp_c_match  <= 1'b0;
    end else begin
      comp_c_match  <= cc_armed && cc_hit;
      break_request <= (session_done && control[CTL_BRK_EN]) || (cc_armed && cc_hit);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, cleared by reading; a new event wins
  logic [IRQ_W-1:0] irq_event;
  logic             status_read;
  logic [IRQ_W-1:0] next_irq_status;

  assign irq_event   = {cc_armed && cc_hit, wrap, session_done};
  assign status_read = rd_done && aligned && (paddr == OFS_IRQ_STATUS);
  // an event in the cycle of the clearing read is kept, so none is lost
  assign next_irq_status = (status_read ? IRQ_RST : irq_status) | irq_event;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_status <= IRQ_RST;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask <= IRQ_RST;
    end else if (wr_irq_mask) begin
      irq_mask <= pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_status & irq_mask);
    end
  end

endmodule : dtcp_top

// >>> tb/dtcp_top_chk.sv
// checker: apb answer timing and read formats at the top ports
module dtcp_top_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  import dtcp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic rd_done = pready && !pwrite;
  ////////////////////////////////////////
  property p_misalign; rd_done && paddr[1:0] != 2'h0 |-> prdata == 32'h0; endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned read not zero");
  property p_trace_w; rd_done && paddr == OFS_TRACE_DATA |-> prdata[31:16] == 16'h0; endproperty
  a_trace_w: assert property (p_trace_w) else $error("trace word wider than 16 bits");
  property p_cnt_fmt; rd_done && paddr == OFS_WORD_COUNT |-> prdata[31:8] == 24'h0 && !prdata[6]; endproperty
  a_cnt_fmt: assert property (p_cnt_fmt) else $error("count register format wrong");
  property p_pgx_fmt; rd_done && paddr == OFS_PAGE_EXT |-> prdata[31:8] == 24'h0; endproperty
  a_pgx_fmt: assert property (p_pgx_fmt) else $error("page extension too wide");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error answer malformed");
  // one wait state, answer stands one cycle
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("answer late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_idle; !psel |=> !pready; endproperty
  a_idle: assert property (p_idle) else $error("ready without request");
endmodule : dtcp_top_chk

bind dtcp_top dtcp_top_chk dtcp_top_chk_inst (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// >>> tb/dtcp_core_model.sv
// partner: core bus and trace word source
module dtcp_core_model (
  // clock
  input wire logic              clk,
  // core side
  output dtcp_pkg::dtcp_core_t  core,
  output dtcp_pkg::dtcp_trace_t trace_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import dtcp_pkg::*;
  initial begin
    core = '0;
    trace_in = '0;
  end
  ////////////////////////////////////////
  // one word a cycle; idle data is inverted so a stale word never looks fresh
  task automatic stream(input int n, input int trig, input logic [15:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      trace_in <= '{1'b1, i == trig, base + 16'(i)};
    end
    @(posedge clk);
    trace_in <= '{1'b0, 1'b0, ~trace_in.data};
  endtask : stream
  task automatic access(input logic [15:0] a, input logic [7:0] x);
    @(posedge clk);
    core <= '{1'b1, a, x, 1'b1};
    @(posedge clk);
    core.valid <= 1'b0;
  endtask : access
endmodule : dtcp_core_model

// >>> tb/dtcp_top_tb.sv
// testbench: trace read port, word counter, interrupts and comparator c paging
module dtcp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dtcp_pkg::*;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic        break_request, comp_c_match, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  dtcp_core_t  core;
  dtcp_trace_t trace_in;
  int          n_mismatch, samples_checked, n_brk, n_hit;
  dtcp_top dtcp_top_inst (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core(core),
    .trace_in(trace_in), .break_request(break_request), .comp_c_match(comp_c_match), .irq(irq));
  dtcp_core_model dtcp_core_model_inst (.clk(clk), .core(core), .trace_in(trace_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (break_request === 1'b1) n_brk++;
    if (comp_c_match === 1'b1) n_hit++;
  end
  ////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // request held until ready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("BAD pready exp 1 got %b", pready);
      tally_and_finish();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rd
  ////////////////////////////////////////
  task automatic t_regs();
    rd(OFS_CONTROL, 32'(CONTROL_RST), "control");
    rd(OFS_PAGE_EXT, 32'(PAGE_EXT_RST), "page_ext");
    rd(OFS_IRQ_MASK, 32'(IRQ_RST), "irq_mask");
    rd(OFS_WORD_COUNT, 32'h0, "count_rst");
    apb(1'b1, OFS_COMP_C, 32'hFFFF1234);
    rd(OFS_COMP_C, 32'h1234, "comp_c");
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped_err", 32'h1, 32'(err));
    chk("unmapped_data", 32'h0, q);
  endtask : t_regs
  // capture mode stays 00 while recording and reading back
  task automatic t_count();
    apb(1'b1, OFS_CONTROL, 32'h01);
    dtcp_core_model_inst.stream(10, -1, 16'hA000);
    rd(OFS_TRACE_DATA, 32'h0, "armed_read");
    rd(OFS_WORD_COUNT, 32'h0A, "count10");
    dtcp_core_model_inst.stream(5, 4, 16'hA00A);
    rd(OFS_WORD_COUNT, 32'h0F, "count15");
    rd(OFS_CONTROL, 32'h0, "end_disarm");
    rd(OFS_TRACE_DATA, 32'hA000, "word0");
    rd(OFS_TRACE_DATA + 8'h2, 32'h0, "misaligned");
    rd(OFS_TRACE_DATA, 32'hA001, "word1");
    rd(OFS_TRACE_DATA, 32'hA002, "word2");
  endtask : t_count
  task automatic t_wrap();
    apb(1'b1, OFS_CONTROL, 32'h01);
    dtcp_core_model_inst.stream(70, 69, 16'hB000);
    rd(OFS_WORD_COUNT, 32'h86, "wrap_count");
    rd(OFS_TRACE_DATA, 32'hB006, "oldest");
    rd(OFS_TRACE_DATA, 32'hB007, "next");
    apb(1'b1, OFS_CONTROL, 32'h01);
    rd(OFS_WORD_COUNT, 32'h0, "arm_clear");
    apb(1'b1, OFS_CONTROL, 32'h0);
  endtask : t_wrap
  task automatic t_begin();
    int b;
    b = n_brk;
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    apb(1'b1, OFS_CONTROL, 32'h07);
    dtcp_core_model_inst.stream(3, -1, 16'hC000);
    rd(OFS_WORD_COUNT, 32'h0, "pre_trigger");
    dtcp_core_model_inst.stream(64, 0, 16'hC100);
    repeat (2) @(posedge clk);
    chk("break_count", 32'(b + 1), 32'(n_brk));
    rd(OFS_WORD_COUNT, 32'h80, "full_count");
    rd(OFS_CONTROL, 32'h06, "begin_disarm");
    rd(OFS_TRACE_DATA, 32'hC100, "begin_word0");
    chk("irq_masked", 32'h0, 32'(irq));
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk("irq_raised", 32'h1, 32'(irq));
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk("status_done", 32'h1, 32'(q[IRQ_DONE]));
    repeat (2) @(posedge clk);
    #1;
    chk("irq_cleared", 32'h0, 32'(irq));
  endtask : t_begin
  task automatic t_page();
    int h;
    apb(1'b1, OFS_CONTROL, 32'h48);
    apb(1'b1, OFS_COMP_C, 32'h4123);
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 2; k++) begin
        apb(1'b1, OFS_PAGE_EXT, {24'h0, 2'(s), 6'h05});
        h = n_hit;
        dtcp_core_model_inst.access(16'h4123, {(k == 1) ? 6'h06 : 6'h05, 2'h1});
        repeat (3) @(posedge clk);
        chk("comp_c_hit", 32'((s % 2 == 0 || k == 0) ? h + 1 : h), 32'(n_hit));
      end
    end
    h = n_hit;
    dtcp_core_model_inst.access(16'h4124, 8'h15);
    repeat (3) @(posedge clk);
    chk("comp_c_miss", 32'(h), 32'(n_hit));
  endtask : t_page
  ////////////////////////////////////////
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_count();
    t_wrap();
    t_begin();
    t_page();
    tally_and_finish();
  end
endmodule : dtcp_top_tb
